// file: core/rotate_pkg.sv
// package: opcode fields, phase codes and reset values for the rotate datapath
package rotate_pkg;
  // instruction word layout
  localparam int          INSTR_W       = 16;
  localparam int          OPC_MSB       = 15;
  localparam int          OPC_LSB       = 9;
  localparam int          DEST_BIT      = 8;
  localparam int          ADDR_MSB      = 7;
  localparam int          DATA_W        = 8;
  localparam logic [6:0]  OPC_RR_CARRY  = 7'h0C;  // 0001 100
  localparam logic [6:0]  OPC_RR_NOCRY  = 7'h10;  // 0010 000
  // reset values
  localparam logic [7:0]  WORK_REG_RST  = 8'h00;
  localparam logic        CARRY_RST     = 1'h0;
  // four phases of one instruction cycle, one-hot
  typedef enum logic [3:0] {
    PH_DECODE  = 4'h1,
    PH_READ    = 4'h2,
    PH_PROCESS = 4'h4,
    PH_WRITE   = 4'h8
  } phase_e;
endpackage

// file: core/rotate_unit.sv
// combinational rotate-right unit for both rotate variants
`timescale 1ns/10ps
module rotate_unit #(
  parameter int DATA_W = 8
) (
  // operand and control
  input  wire logic [DATA_W-1:0] operand,
  input  wire logic              carry_in,
  input  wire logic              use_carry,
  // result
  output logic      [DATA_W-1:0] result,
  output logic                   carry_out
);
  // bit 7 fill comes from carry or from the wrapped low bit
  always_comb begin
    result    = {(use_carry ? carry_in : operand[0]), operand[DATA_W-1:1]};
    carry_out = operand[0];
  end
endmodule // rotate_unit

// file: core/rotate_right_datapath.sv
// rotate-right datapath: decode, read, process and write over four phases
//
// Summary of operation
// - through-carry: shift right, bit0 to carry, carry to bit7
// - dest zero: result to working register only
// - dest one: result written back to addressed byte
// - no-carry: shift right, bit0 to bit7, flags kept
// - no-carry dest selects working register or byte
// - decode through-carry from upper bits 0001100
// - decode no-carry from upper bits 0010000
//
// timing of one taken word, E being the taking edge
// E   : fields latched, read address registered
// E+1 : operand sampled from the register file
// E+2 : rotated byte and next carry held
// E+3 : destination, carry flag, rf_we and done updated
// E+4 : decode again, the next word may be taken
//
// port groups in short
// issue: instr_valid is a level, a word is looked at in decode only
// read port: rf_raddr registered, rf_rdata sampled one edge later
// write port: rf_we pulses one cycle with rf_waddr and rf_wdata
// state: working_register and carry_flag, both registered
// status: busy for the three cycles after a take, done for one
//
// limitation: words offered while busy are dropped, not queued,
// so the issuer must hold a word until busy is low again
// hazard: a write-back is a one-cycle rf_we pulse beside done; the
// file must take it at the edge that ends it, before the next read
// trade-off: four edges per word keep the read and write ports
// apart, at a quarter of the full issue rate
`timescale 1ns/10ps
module rotate_right_datapath
#(
  parameter int DW = rotate_pkg::DATA_W
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // instruction issue
  input  wire logic                          instr_valid,
  input  wire logic [rotate_pkg::INSTR_W-1:0] instr_word,
  // register file read port
  output logic      [7:0]                    rf_raddr,
  input  wire logic [DW-1:0]                 rf_rdata,
  // register file write port
  output logic                               rf_we,
  output logic      [7:0]                    rf_waddr,
  output logic      [DW-1:0]                 rf_wdata,
  // architectural state
  output logic      [DW-1:0]                 working_register,
  output logic                               carry_flag,
  // status
  output logic                               busy,
  output logic                               done
);
  import rotate_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing and latched fields
  phase_e          phase_r;
  logic            is_carry_r;
  logic            dest_r;
  logic [7:0]      addr_r;
  // datapath
  logic [DW-1:0]   operand_r;
  logic [DW-1:0]   result_r;
  logic [DW-1:0]   rot_result;
  logic            rot_carry;
  logic            carry_nxt_r;
  // decode
  logic [6:0]      opc_field;
  logic            dest_field;
  logic [7:0]      addr_field;
  logic            hit_carry;
  logic            hit_nocry;
  logic            take;

  // instruction word fields
  assign opc_field  = instr_word[OPC_MSB:OPC_LSB];
  assign dest_field = instr_word[DEST_BIT];
  assign addr_field = instr_word[ADDR_MSB:0];

  // opcode match on the upper seven bits
  assign hit_carry = opc_field == OPC_RR_CARRY;
  assign hit_nocry = opc_field == OPC_RR_NOCRY;

  // a word is taken only in decode; other words change nothing but rf_raddr
  assign take = (phase_r == PH_DECODE) && instr_valid && (hit_carry || hit_nocry);

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencer; unknown words never leave decode
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_r <= PH_DECODE;
    end else begin
      unique case (phase_r)
        PH_DECODE: begin
          if (instr_valid && (hit_carry || hit_nocry)) begin
            phase_r <= PH_READ;
          end
        end
        PH_READ:    phase_r <= PH_PROCESS;
        PH_PROCESS: phase_r <= PH_WRITE;
        PH_WRITE:   phase_r <= PH_DECODE;
        default:    phase_r <= PH_DECODE;
      endcase
    end
  end

  // latch decoded fields
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      is_carry_r <= 1'h0;
      dest_r     <= 1'h0;
      addr_r     <= 8'h00;
    end else if (take) begin
      is_carry_r <= hit_carry;
      dest_r     <= dest_field;
      addr_r     <= addr_field;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read address is held from a flop so the port is registered
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rf_raddr <= 8'h00;
    end else if (phase_r == PH_DECODE && instr_valid) begin
      rf_raddr <= addr_field;
    end
  end

  // capture operand during read phase
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      operand_r <= '0;
    end else if (phase_r == PH_READ) begin
      operand_r <= rf_rdata;
    end
  end

  // carry_in is the flag from before this word
  rotate_unit #(
    .DATA_W (DW)
  ) u_rot (
    .operand   (operand_r),
    .carry_in  (carry_flag),
    .use_carry (is_carry_r),
    .result    (rot_result),
    .carry_out (rot_carry)
  );

  // process phase stores result and new carry
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      result_r    <= '0;
      carry_nxt_r <= CARRY_RST;
    end else if (phase_r == PH_PROCESS) begin
      result_r    <= rot_result;
      carry_nxt_r <= is_carry_r ? rot_carry : carry_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // carry moves only in write phase; the no-carry path reloads the old value
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      carry_flag <= CARRY_RST;
    end else if (phase_r == PH_WRITE) begin
      carry_flag <= carry_nxt_r;
    end
  end

  // working register takes the result only when dest is zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      working_register <= WORK_REG_RST;
    end else if (phase_r == PH_WRITE && !dest_r) begin
      working_register <= result_r;
    end
  end

  // write strobe: a one-cycle pulse, never held between words
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rf_we <= 1'h0;
    end else begin
      rf_we <= (phase_r == PH_WRITE) && dest_r;
    end
  end

  // write address and data hold their last value between pulses
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rf_waddr <= 8'h00;
      rf_wdata <= '0;
    end else if (phase_r == PH_WRITE && dest_r) begin
      rf_waddr <= addr_r;
      rf_wdata <= result_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // busy covers read, process and write phases of a taken word
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy <= 1'h0;
    end else begin
      busy <= (phase_r == PH_DECODE) ? take : (phase_r != PH_WRITE);
    end
  end

  // done pulses once, in the cycle the results become visible
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done <= 1'h0;
    end else begin
      done <= phase_r == PH_WRITE;
    end
  end
endmodule // rotate_right_datapath

// file: dv/rotate_right_props.sv
// checker: port properties of the rotate-right datapath
`timescale 1ns/10ps
module rotate_right_props
  import rotate_pkg::*;
#(parameter int DW = 8) (
  // watched ports, grouped by width
  input wire logic               clk, reset_n, instr_valid, rf_we, carry_flag, busy, done,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic [7:0]         rf_raddr, rf_waddr,
  input wire logic [DW-1:0]      rf_rdata, rf_wdata, working_register
);
  // a rotate word offered while idle is taken
  wire cy = instr_word[15:9] == OPC_RR_CARRY;
  wire tk = instr_valid & ~busy & (cy | instr_word[15:9] == OPC_RR_NOCRY);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // old carry, not the new one, feeds bit 7
  property res_p(logic dst);
    tk & instr_word[8] == dst |-> ##4 done && rf_we == dst && (dst ? rf_wdata : working_register)
      == {$past(cy, 4) ? $past(carry_flag, 4) : $past(rf_rdata[0], 3), $past(rf_rdata[7:1], 3)};
  endproperty
  AST_RADDR: assert property (tk |=> rf_raddr == $past(instr_word[7:0]))
    else $error("bad read address");
  AST_BUSY: assert property (tk |=> busy [*3] ##1 !busy)
    else $error("bad busy span");
  AST_DONE: assert property ($rose(done) |-> $past(tk, 4))
    else $error("stray done");
  AST_CY: assert property (tk & cy |-> ##4 carry_flag == $past(rf_rdata[0], 3))
    else $error("bad carry");
  AST_NC: assert property (tk & ~cy |-> ##4 carry_flag == $past(carry_flag, 4))
    else $error("carry moved");
  AST_TO_W: assert property (res_p(1'b0))
    else $error("bad working result");
  AST_TO_F: assert property (res_p(1'b1))
    else $error("bad write back");
  AST_WADDR: assert property (tk & instr_word[8] |-> ##4
    rf_waddr == $past(instr_word[7:0], 4) && working_register == $past(working_register, 4))
    else $error("bad write address");
  cover property (tk & cy & instr_word[8]);
  cover property (tk & ~cy & ~instr_word[8]);
  cover property (tk & done);
endmodule // rotate_right_props
bind rotate_right_datapath rotate_right_props #(.DW(DW)) props_u (.*);

// file: dv/tb.sv
// testbench: rotate words against a model with a byte store
`timescale 1ns/10ps
module tb;
  import rotate_pkg::*;
  logic        clk = 0, reset_n = 0, instr_valid = 0, rf_we, carry_flag, busy, done, ec = 0;
  logic [15:0] instr_word = 0;
  logic [7:0]  rf_raddr, rf_waddr, rf_wdata, working_register, ew = 0;
  logic [7:0]  mem [256], em [256];
  logic [25:0] eq [$], e;
  int          fail_count = 0, tests_run = 0, cyc = 0;
  wire logic [7:0] rf_rdata = mem[rf_raddr];
  rotate_right_datapath #(.DW(8)) dut_u (.*);
  initial forever #5 clk = ~clk;
  ////////////////////////////////
  // byte store writes at the edge; cycle ceiling cuts a hang
  always @(posedge clk) begin
    if (rf_we) mem[rf_waddr] <= rf_wdata;
    if (++cyc == 1000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    tests_run++;
    if (g !== x) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  // results return in issue order, one per done pulse
  always @(negedge clk) if (done === 1'b1) begin
    e = eq.size() ? eq.pop_front() : '1;
    chk("we", 8'(e[25]), 8'(rf_we));
    if (e[25]) chk("waddr", e[24:17], rf_waddr);
    if (e[25]) chk("wdata", e[16:9], rf_wdata);
    chk("working_register", e[8:1], working_register);
    chk("carry", 8'(e[0]), 8'(carry_flag));
  end
  // model first, then offer the word; a rotate word held while busy must be ignored
  task automatic run(input logic [6:0] op, input logic d, input logic [7:0] a);
    logic [7:0] r;
    r = {op == OPC_RR_CARRY ? ec : em[a][0], em[a][7:1]};
    if (op == OPC_RR_CARRY) ec = em[a][0];
    if (d) em[a] = r;
    else ew = r;
    eq.push_back({d, a, r, ew, ec});
    instr_valid <= 1'b1;
    instr_word <= {op, d, a};
    @(posedge clk);
    instr_word <= {OPC_RR_CARRY, 1'b1, 8'($urandom)};
    repeat (3) @(posedge clk);
  endtask
  task automatic close_out();
    chk("pending", 8'h00, 8'(eq.size()));
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////
  // few addresses so write-backs are read again; back-to-back issue throughout
  initial begin
    void'($urandom(76583));
    for (int k = 0; k < 256; k++) begin
      mem[k] = 8'($urandom);
      em[k] = mem[k];
    end
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      run(i[0] ? OPC_RR_CARRY : OPC_RR_NOCRY, i[1], i < 4 ? 8'hFF : 8'($urandom % 4));
    end
    instr_word <= 16'h2200; // not a rotate word: nothing but rf_raddr may change
    repeat (4) @(posedge clk);
    instr_valid <= 1'b0;
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule // tb
